// [verification/serial_dac_load_interface_tb_top.sv]
// bench for the serial converter load port
// assumes the host model drives the pins and the bench sinks the code stream
`timescale 1ns/10ps
module serial_dac_load_interface_tb_top;
   import serial_dac_pkg::*;
   logic              sys_clk, sys_rst, serial_clk, serial_din, select_load_n, serial_dout;
   logic              dac_code_valid, dac_code_ready, full_scale, load_dropped;
   logic [CODE_W-1:0] dac_code;
   int                n_mismatch, checks, n_drop;
   ////////////////////////////////////////////////////////////////////////////
   serial_host_model host (.sys_clk(sys_clk), .serial_clk(serial_clk), .serial_din(serial_din),
      .select_load_n(select_load_n));
   serial_dac_load_interface uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
      .serial_din(serial_din), .select_load_n(select_load_n), .serial_dout(serial_dout),
      .dac_code(dac_code), .dac_code_valid(dac_code_valid), .dac_code_ready(dac_code_ready),
      .full_scale(full_scale), .load_dropped(load_dropped));
   initial sys_clk = 1'b0;
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (load_dropped === 1'b1) n_drop++;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // sink one word; waits two cycles after so valid can refresh
   task automatic pop(input logic [11:0] exp);
      for (int i = 0; i < 300 && dac_code_valid !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk("dac_code_valid", 12'h001, {11'h000, dac_code_valid});
      chk("dac_code", exp, dac_code);
      dac_code_ready = 1'b1;
      @(posedge sys_clk);
      #1;
      dac_code_ready = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_load(input logic [11:0] code);
      host.frame(code);
      pop(code);
      chk("full_scale", {11'h000, code === CODE_FULL}, {11'h000, full_scale});
      chk("serial_dout", {11'h000, code[11]}, {11'h000, serial_dout});
   endtask
   // full scale must stay while a new frame shifts
   task automatic t_hold();
      fork
         host.frame(12'h001);
         begin
            repeat (60) @(posedge sys_clk);
            #1;
            chk("full_scale", 12'h001, {11'h000, full_scale});
         end
      join
      pop(12'h001);
      chk("full_scale", 12'h000, {11'h000, full_scale});
   endtask
   // ones clocked with select high would turn the code into 00F
   task automatic t_gate();
      host.stray(3);
      host.reload();
      pop(12'h001);
   endtask
   // buffer and output stage keep three codes; the fourth load is lost
   task automatic t_buffer();
      n_drop = 0;
      host.frame(12'h111);
      host.frame(12'h222);
      host.frame(12'h333);
      host.frame(12'h444);
      repeat (8) @(posedge sys_clk);
      #1;
      chk("drop count", 12'h001, n_drop[11:0]);
      pop(12'h111);
      pop(12'h222);
      pop(12'h333);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("dac_code_valid", 12'h000, {11'h000, dac_code_valid});
   endtask
   // reset in mid-run with code, flag and output bit all set, then a fresh load
   task automatic t_reset();
      host.frame(12'hFFF);
      sys_rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      chk("reset outputs", 12'h000, {8'h00, serial_dout, dac_code_valid, full_scale, load_dropped});
      chk("dac_code", CODE_RESET, dac_code);
      repeat (3) @(posedge sys_clk);
      #1;
      t_load(12'h3C3);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      dac_code_ready = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      chk("reset outputs", 12'h000, {8'h00, serial_dout, dac_code_valid, full_scale, load_dropped});
      chk("dac_code", CODE_RESET, dac_code);
      repeat (3) @(posedge sys_clk);
      #1;
      t_load(12'hA5C);
      t_load(12'h5A3);
      t_load(12'hFFF);
      t_hold();
      t_gate();
      t_buffer();
      t_reset();
      end_of_test();
   end
   // watchdog: about 30000 cycles against some 1200 needed
   initial begin
      #3_000_000;
      n_mismatch++;
      end_of_test();
   end
endmodule

// [verification/serial_host_model.sv]
// host model driving the serial pins of the converter load port
// assumes tasks are called from the bench; link clock stands low between frames
`timescale 1ns/10ps
module serial_host_model (
   input  wire logic sys_clk,
   output logic      serial_clk,
   output logic      serial_din,
   output logic      select_load_n
);
   initial begin
      serial_clk = 1'b0;
      serial_din = 1'b0;
      select_load_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // half of an 800 ns link clock period
   task automatic half();
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   task automatic frame(input logic [11:0] code);
      half();
      select_load_n = 1'b0; // clock already low here
      for (int i = 11; i >= 0; i--) begin
         serial_din = code[i]; // msb first, descending
         half();
         serial_clk = 1'b1;
         half();
         serial_clk = 1'b0;
      end
      half();
      select_load_n = 1'b1;
      serial_din = ~code[0]; // released line must not keep last bit
      half();
   endtask
   // clock pulses with select high, ones on data
   task automatic stray(input int n);
      serial_din = 1'b1;
      repeat (n) begin
         half();
         serial_clk = 1'b1;
         half();
         serial_clk = 1'b0;
      end
      half();
   endtask
   task automatic reload();
      select_load_n = 1'b0; // clock low
      half();
      select_load_n = 1'b1;
      half();
   endtask
endmodule

// [verilog/code_buffer.sv]
// two-entry buffer for loaded codes
// assumes one clock domain; sink may stall
`timescale 1ns/10ps
module code_buffer (
   input  wire logic                            sys_clk,
   input  wire logic                            sys_rst,
   input  wire logic [serial_dac_pkg::CODE_W-1:0] in_data,
   input  wire logic                            in_valid,
   output logic                                 in_ready,
   output logic [serial_dac_pkg::CODE_W-1:0]    out_data,
   output logic                                 out_valid,
   input  wire logic                            out_ready
);
   import serial_dac_pkg::*;
   logic [CODE_W-1:0] mem_r   [BUF_DEPTH];
   logic [CODE_W-1:0] mem_nxt [BUF_DEPTH];
   logic [1:0]        cnt_r;
   logic [1:0]        cnt_nxt;
   logic              push;
   logic              pop;
   always_comb begin
      push       = in_valid && in_ready;
      pop        = out_valid && out_ready;
      in_ready   = (cnt_r != 2'h2);
      out_valid  = (cnt_r != 2'h0);
      out_data   = mem_r[0];
      mem_nxt[0] = mem_r[0];
      mem_nxt[1] = mem_r[1];
      cnt_nxt    = cnt_r;
      if (pop) begin
         mem_nxt[0] = mem_r[1];
      end
      if (push) begin
         if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
            mem_nxt[0] = in_data;
         end else begin
            mem_nxt[1] = in_data;
         end
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_r    <= 2'h0;
         mem_r[0] <= CODE_RESET;
         mem_r[1] <= CODE_RESET;
      end else begin
         cnt_r    <= cnt_nxt;
         mem_r[0] <= mem_nxt[0];
         mem_r[1] <= mem_nxt[1];
      end
   end
endmodule

// [verilog/serial_dac_load_interface.sv]
// serial load port of a 12-bit voltage-output converter
// assumes serial pins are asynchronous to sys_clk and slow against it
//
// Notes on behaviour
// - each serial clock rising edge while select_load_n is low captures the data input into the shift register
// - serial clock edges are ignored while select_load_n is high
// - select_load_n rising copies the shift register into the converter register
// - serial data output shows shift register msb, updated after a rising edge
// - shift register and converter register are both 12 bits wide
// - code 4095, all ones, is full scale; flagged on full_scale
`timescale 1ns/10ps
module serial_dac_load_interface (
   input  wire logic                              sys_clk,
   input  wire logic                              sys_rst,
   input  wire logic                              serial_clk,
   input  wire logic                              serial_din,
   input  wire logic                              select_load_n,
   output logic                                   serial_dout,
   output logic [serial_dac_pkg::CODE_W-1:0]      dac_code,
   output logic                                   dac_code_valid,
   input  wire logic                              dac_code_ready,
   output logic                                   full_scale,
   output logic                                   load_dropped
);
   import serial_dac_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage read only by the second
   logic [SYNC_STAGES-1:0] sclk_sync_r;
   logic [SYNC_STAGES-1:0] din_sync_r;
   logic [SYNC_STAGES-1:0] sel_sync_r;
   logic                   sclk_d_r;
   logic                   sel_d_r;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sclk_sync_r <= '0;
         din_sync_r  <= '0;
         sel_sync_r  <= '1;
         sclk_d_r    <= 1'b0;
         sel_d_r     <= 1'b1;
      end else begin
         sclk_sync_r <= {sclk_sync_r[0], serial_clk};
         din_sync_r  <= {din_sync_r[0], serial_din};
         sel_sync_r  <= {sel_sync_r[0], select_load_n};
         sclk_d_r    <= sclk_sync_r[1];
         sel_d_r     <= sel_sync_r[1];
      end
   end
   logic sclk_rise;
   logic sel_rise;
   logic sel_low;
   logic din_s;
   // data synchroniser is as deep as clock's so setup relation holds
   assign din_s     = din_sync_r[1];
   assign sel_low   = !sel_sync_r[1];
   assign sclk_rise = sclk_sync_r[1] && !sclk_d_r;
   assign sel_rise  = sel_sync_r[1] && !sel_d_r;
   ////////////////////////////////////////////////////////////////////////////
   // shift path
   port_state_e       state_r;
   port_state_e       state_nxt;
   logic [CODE_W-1:0] shift_r;
   logic [CODE_W-1:0] shift_nxt;
   logic              dout_r;
   logic              dout_nxt;
   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      dout_nxt  = dout_r;
      case (state_r)
         ST_IDLE: begin
            if (sel_low && !sclk_sync_r[1]) begin
               // entering with clock high would fake an edge; host keeps it low
               state_nxt = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (!sel_low) begin
               state_nxt = ST_IDLE; // edges ignored while deselected
            end else if (sclk_rise) begin
               shift_nxt = {shift_r[CODE_W-2:0], din_s}; // msb first
               dout_nxt  = shift_r[CODE_W-2]; // outgoing bit after the edge
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         shift_r <= CODE_RESET;
         dout_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         dout_r  <= dout_nxt;
      end
   end
   assign serial_dout = dout_r;
   ////////////////////////////////////////////////////////////////////////////
   // converter register, loaded only on select rising
   logic [CODE_W-1:0] conv_r;
   logic [CODE_W-1:0] conv_nxt;
   logic              full_r;
   logic              full_nxt;
   logic              drop_r;
   logic              drop_nxt;
   logic              buf_in_ready;
   logic [CODE_W-1:0] buf_data;
   logic              buf_valid;
   logic              buf_pop;
   always_comb begin
      conv_nxt = conv_r;
      drop_nxt = 1'b0;
      if (sel_rise) begin
         conv_nxt = shift_r;
         drop_nxt = !buf_in_ready;
      end
      full_nxt = (conv_nxt == CODE_FULL);
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         conv_r <= CODE_RESET;
         full_r <= 1'b0;
         drop_r <= 1'b0;
      end else begin
         conv_r <= conv_nxt;
         full_r <= full_nxt;
         drop_r <= drop_nxt;
      end
   end
   assign full_scale   = full_r;
   assign load_dropped = drop_r;
   ////////////////////////////////////////////////////////////////////////////
   // loaded codes to the analog side; a stall there keeps three codes
   code_buffer u_buf (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_data   (shift_r),
      .in_valid  (sel_rise),
      .in_ready  (buf_in_ready),
      .out_data  (buf_data),
      .out_valid (buf_valid),
      .out_ready (buf_pop)
   );
   logic [CODE_W-1:0] code_out_r;
   logic [CODE_W-1:0] code_out_nxt;
   logic              code_vld_r;
   logic              code_vld_nxt;
   // output stage refills only when empty or being taken, so a stall loses nothing
   // and a sink holding ready high takes each code exactly once
   always_comb begin
      buf_pop      = !code_vld_r || dac_code_ready;
      code_out_nxt = code_out_r;
      code_vld_nxt = code_vld_r;
      if (buf_pop) begin
         code_vld_nxt = buf_valid;
         if (buf_valid) begin
            code_out_nxt = buf_data;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         code_out_r <= CODE_RESET;
         code_vld_r <= 1'b0;
      end else begin
         code_out_r <= code_out_nxt;
         code_vld_r <= code_vld_nxt;
      end
   end
   // buffer plus this stage hold three codes; a fourth unread load is dropped
   assign dac_code       = code_out_r;
   assign dac_code_valid = code_vld_r;
   ////////////////////////////////////////////////////////////////////////////
   // checks
   // they watch registered state; pin timing is left to the host side
   sequence s_load;
      sel_rise ##1 1'b1;
   endsequence
   a_load_copies: assert property (@(posedge sys_clk) disable iff (sys_rst)
      sel_rise |=> (conv_r == $past(shift_r))) else $error("load did not copy shift");
   a_hold_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !sel_rise |=> $stable(conv_r)) else $error("converter code changed without load");
   a_no_shift_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state_r == ST_IDLE) |=> $stable(shift_r)) else $error("shift while deselected");
   a_sel_high_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !sel_low |=> (state_r == ST_IDLE)) else $error("port armed while deselected");
   a_shift_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state_r == ST_SHIFT && sel_low && sclk_rise) |=> shift_r[0] == $past(din_s))
      else $error("serial bit not captured");
   a_dout_msb: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state_r == ST_SHIFT && sel_low && sclk_rise) |=> serial_dout == shift_r[CODE_W-1])
      else $error("output bit not msb");
   a_dout_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !(state_r == ST_SHIFT && sel_low && sclk_rise) |=> $stable(serial_dout))
      else $error("output bit moved without a clock edge");
   a_full_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_load |-> (full_scale == ($past(shift_r) == CODE_FULL))) else $error("full scale flag wrong");
   a_enter_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(state_r == ST_SHIFT) |-> !sclk_d_r) else $error("shift armed with clock high");
   a_width_msb: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state_r == ST_SHIFT && sel_low && sclk_rise) |=> shift_r[CODE_W-1] == $past(shift_r[CODE_W-2]))
      else $error("shift not msb first");
   a_valid_after_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (sel_rise && buf_in_ready) |-> ##2 dac_code_valid) else $error("loaded code not offered");
   a_out_stall: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dac_code_valid && !dac_code_ready) |=> (dac_code_valid && $stable(dac_code)))
      else $error("offered code changed before it was taken");
   a_drop_full: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (sel_rise && !buf_in_ready) |=> load_dropped) else $error("lost load not flagged");
endmodule

// [verilog/serial_dac_pkg.sv]
// constants for the serial converter load port
// assumes a 10 MHz system clock sampling the serial pins
package serial_dac_pkg;
   localparam int           CODE_W       = 12;
   localparam logic [11:0]  CODE_RESET   = 12'h000;
   localparam logic [11:0]  CODE_FULL    = 12'hFFF;
   localparam int           SYNC_STAGES  = 2;
   localparam int           BUF_DEPTH    = 2;
   localparam int           CLK_PERIOD_NS = 100;
   localparam int           DOUT_DELAY_NS = 150;
   localparam int           DOUT_DELAY_CYC = (DOUT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                             (DOUT_DELAY_NS / CLK_PERIOD_NS);
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01
   } port_state_e;
endpackage
